// *** rtl/plm_top.sv ***
// lock status and multiplier registers behind an ahb-lite slave
// assumes a single zero-wait slave on the bus; hreadyout is the bus hready
//
// How it works
// - sticky loss flag, status bit 7, sets when acquired lock is later lost
// - interrupt request follows the loss flag only when irq enable is set
// - reset request follows the loss flag only when reset enable is set
// - loss flag clears on reset or on a software write of one
// - writing zero to the loss flag position leaves it unchanged
// - changing the vco select while locked clears locked until relock
// - pll output clock stays gated while enabled and not locked
`default_nettype none
module plm_top (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // pll side
    input wire logic pll_lock_raw,
    input wire logic pll_enable,
    output logic pll_clock_gate_en,
    output logic [5:0] pll_multiply_factor,
    output logic osc_clock_monitor_enable,
    // requests to the system
    output logic lock_loss_irq,
    output logic lock_loss_reset_req
);
    plm_lock_if lk ();

    logic wr_pend_q, wr_pend_d;
    logic [plm_pkg::ADDR_W-1:0] wr_addr_q, wr_addr_d;
    logic [7:0] ctrl_q, ctrl_d;
    logic rst_en_q, rst_en_d;
    logic loss_q, loss_d;
    logic irq_q, irq_d;
    logic rreq_q, rreq_d;
    logic [5:0] mult_q, mult_d;
    logic mon_q, mon_d;
    logic [31:0] rdata_q, rdata_d;
    logic rd_pend_q, rd_pend_d;
    logic addr_ph;
    logic wr_ctrl, wr_status, wr_cfg, clr_loss;
    logic [plm_pkg::ADDR_W-1:0] a_addr;
    logic [4:0] vdiv_d;

    // hsize is not checked: only whole-word transfers are used
    assign addr_ph = hsel && hready && (htrans == plm_pkg::HTRANS_NONSEQ);
    assign a_addr = haddr[plm_pkg::ADDR_W-1:0];
    assign wr_ctrl = wr_pend_q && (wr_addr_q == plm_pkg::ADDR_VCO_CTRL);
    assign wr_status = wr_pend_q && (wr_addr_q == plm_pkg::ADDR_STATUS);
    assign wr_cfg = wr_pend_q && (wr_addr_q == plm_pkg::ADDR_LOCK_CFG);
    assign clr_loss = wr_status && hwdata[plm_pkg::BIT_LOSS];

    always_comb begin
        wr_pend_d = addr_ph && hwrite;
        wr_addr_d = addr_ph ? a_addr : wr_addr_q;
        ctrl_d = ctrl_q;
        rst_en_d = rst_en_q;
        if (wr_ctrl) begin
            // bit 6 is not implemented here and reads zero
            ctrl_d = hwdata[7:0];
            ctrl_d[plm_pkg::BIT_CTRL_UNUSED] = 1'b0;
        end
        if (wr_cfg) begin
            rst_en_d = hwdata[plm_pkg::BIT_RST_EN];
        end
        // a new loss in the clearing cycle wins over the clear
        loss_d = lk.loss_event || (loss_q && !clr_loss);
        // requests are levels that drop with the flag, not one-cycle pulses
        irq_d = loss_d && ctrl_d[plm_pkg::BIT_IRQ_EN];
        rreq_d = loss_d && rst_en_d;
        mon_d = ctrl_d[plm_pkg::BIT_OSC_MON];
        vdiv_d = ctrl_d[plm_pkg::VDIV_MSB:0];
        // six bits hold the largest factor, code 31 plus 24
        mult_d = {1'b0, vdiv_d} + plm_pkg::MULT_BASE;
    end

    // read data from next-state values, except the locked bit, so a write then read is not stale
    always_comb begin
        rd_pend_d = addr_ph && !hwrite;
        rdata_d = 32'h0000_0000;
        if (rd_pend_d) begin
            unique case (a_addr)
                plm_pkg::ADDR_VCO_CTRL: rdata_d[7:0] = ctrl_d;
                plm_pkg::ADDR_STATUS: begin
                    rdata_d[plm_pkg::BIT_LOSS] = loss_d;
                    rdata_d[plm_pkg::BIT_LOCKED] = lk.locked;
                end
                plm_pkg::ADDR_LOCK_CFG: rdata_d[plm_pkg::BIT_RST_EN] = rst_en_d;
                default: rdata_d = 32'h0000_0000;
            endcase
        end
    end

    // rewriting the same select code must not force a relock
    assign lk.vdiv_change = wr_ctrl
        && (hwdata[plm_pkg::VDIV_MSB:0] != ctrl_q[plm_pkg::VDIV_MSB:0]);

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= '0;
            ctrl_q <= plm_pkg::VCO_CTRL_RST;
            rst_en_q <= plm_pkg::RST_EN_RST;
            loss_q <= 1'b0;
            irq_q <= 1'b0;
            rreq_q <= 1'b0;
            mult_q <= plm_pkg::MULT_BASE;
            mon_q <= 1'b0;
        end else begin
            wr_pend_q <= wr_pend_d;
            wr_addr_q <= wr_addr_d;
            ctrl_q <= ctrl_d;
            rst_en_q <= rst_en_d;
            loss_q <= loss_d;
            irq_q <= irq_d;
            rreq_q <= rreq_d;
            mult_q <= mult_d;
            mon_q <= mon_d;
        end
    end

    // read data returns to zero after its one data-phase cycle
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            rd_pend_q <= 1'b0;
            rdata_q <= 32'h0000_0000;
        end else begin
            rd_pend_q <= rd_pend_d;
            rdata_q <= rdata_d;
        end
    end

    plm_lock_track u_track (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pll_lock_raw(pll_lock_raw),
        .pll_enable(pll_enable),
        .pll_clock_gate_en(pll_clock_gate_en),
        .lk(lk.tracker)
    );

    // zero-wait slave: every transfer completes in its first data-phase cycle
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = rdata_q;
    assign pll_multiply_factor = mult_q;
    assign osc_clock_monitor_enable = mon_q;
    assign lock_loss_irq = irq_q;
    assign lock_loss_reset_req = rreq_q;

    // read data is checked in its data phase against the state it was taken from
    sequence seq_loss;
        lk.loss_event;
    endsequence
    sequence seq_status_read;
        rd_pend_q && (wr_addr_q == plm_pkg::ADDR_STATUS);
    endsequence
    sequence seq_ctrl_read;
        rd_pend_q && (wr_addr_q == plm_pkg::ADDR_VCO_CTRL);
    endsequence
    sequence seq_clear_one;
        wr_status && hwdata[plm_pkg::BIT_LOSS] && !lk.loss_event;
    endsequence

    AST_LOSS_SET: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_loss |=> loss_q)
        else $error("loss flag did not set on loss of lock");
    AST_LOSS_STICKY: assert property (@(posedge ref_clk) disable iff (!reset_n)
        loss_q && !wr_status |=> loss_q)
        else $error("loss flag dropped without a clear");
    AST_IRQ_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        lock_loss_irq == (loss_q && ctrl_q[plm_pkg::BIT_IRQ_EN]))
        else $error("interrupt request does not follow flag and enable");
    AST_RST_GATE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_loss ##1 (rst_en_q && !wr_status) |-> lock_loss_reset_req)
        else $error("reset request missing after loss with enable");
    AST_W1C: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_clear_one |=> !loss_q && !lock_loss_irq && !lock_loss_reset_req)
        else $error("write of one did not clear the loss flag");
    AST_W0_KEEP: assert property (@(posedge ref_clk) disable iff (!reset_n)
        loss_q && wr_status && !hwdata[plm_pkg::BIT_LOSS] |=> loss_q)
        else $error("write of zero changed the loss flag");
    AST_MON_EN: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_ctrl |=> osc_clock_monitor_enable == $past(hwdata[plm_pkg::BIT_OSC_MON]))
        else $error("monitor enable does not follow its control bit");
    AST_MULT: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_ctrl |=> pll_multiply_factor == {1'b0, $past(hwdata[4:0])} + plm_pkg::MULT_BASE)
        else $error("multiply factor is not code plus 24");
    AST_STATUS_LOSS: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_status_read |-> hrdata[plm_pkg::BIT_LOSS] == loss_q)
        else $error("status read does not show the loss flag");
    AST_STATUS_LOCK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_status_read |-> hrdata[plm_pkg::BIT_LOCKED] == $past(lk.locked))
        else $error("status read does not show the locked flag");
    AST_CTRL_READ: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_ctrl_read |-> hrdata[7:0] == ctrl_q)
        else $error("control read does not show the control register");
    AST_IRQ_MASK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !ctrl_q[plm_pkg::BIT_IRQ_EN] |-> !lock_loss_irq)
        else $error("interrupt request raised with its enable off");
    AST_RREQ_MASK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !rst_en_q |-> !lock_loss_reset_req)
        else $error("reset request raised with its enable off");
    AST_MON_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_ctrl |=> $stable(osc_clock_monitor_enable))
        else $error("monitor enable changed without a control write");
    AST_MULT_STABLE: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !wr_ctrl |=> $stable(pll_multiply_factor))
        else $error("multiply factor changed without a control write");
endmodule
`default_nettype wire

// *** include/plm_pkg.sv ***
// constants shared by the lock status and multiplier block
// assumes a 32-bit AHB-Lite register bus with word-aligned registers
`default_nettype none
package plm_pkg;
    localparam int unsigned ADDR_W = 8;
    // register indices; byte address is four times the index
    localparam logic [ADDR_W-1:0] IDX_VCO_CTRL = 8'h05;
    localparam logic [ADDR_W-1:0] IDX_STATUS = 8'h06;
    localparam logic [ADDR_W-1:0] IDX_LOCK_CFG = 8'h08;
    localparam logic [ADDR_W-1:0] ADDR_VCO_CTRL = 8'h14;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h18;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_CFG = 8'h20;
    // field positions
    localparam int unsigned BIT_IRQ_EN = 7;
    localparam int unsigned BIT_OSC_MON = 5;
    localparam int unsigned VDIV_MSB = 4;
    localparam int unsigned BIT_LOSS = 7;
    localparam int unsigned BIT_LOCKED = 6;
    localparam int unsigned BIT_RST_EN = 0;
    localparam int unsigned BIT_CTRL_UNUSED = 6;
    // reset values
    localparam logic [7:0] VCO_CTRL_RST = 8'h00;
    localparam logic RST_EN_RST = 1'b0;
    // multiply factor of vdiv code zero
    localparam logic [5:0] MULT_BASE = 6'h18;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
endpackage
`default_nettype wire

// *** include/plm_lock_if.sv ***
// carries lock state between the register file and the lock tracker
// assumes both ends sit on the same ref_clk
`default_nettype none
interface plm_lock_if;
    logic vdiv_change;
    logic locked;
    logic loss_event;
    modport tracker (input vdiv_change, output locked, output loss_event);
    modport regs (output vdiv_change, input locked, input loss_event);
endinterface
`default_nettype wire

// *** rtl/plm_lock_track.sv ***
// lock tracker: synchronises the analog lock detect, keeps the locked flag,
// reports loss of lock and drives the pll output clock gate
// assumes pll_lock_raw is asynchronous and pll_enable is on ref_clk
`default_nettype none
module plm_lock_track (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // pll side
    input wire logic pll_lock_raw,
    input wire logic pll_enable,
    output logic pll_clock_gate_en,
    // register side
    plm_lock_if.tracker lk
);
    logic sync1_q, sync2_q;
    logic locked_q, locked_d;
    logic hold_q, hold_d;
    logic acq_q, acq_d;
    logic gate_q, gate_d;
    logic loss_d;

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
        end else begin
            sync1_q <= pll_lock_raw;
            sync2_q <= sync1_q;
        end
    end

    always_comb begin
        // a multiplier change forces relock; hold until detector drops
        hold_d = hold_q;
        if (lk.vdiv_change && locked_q) begin
            hold_d = 1'b1;
        end else if (!sync2_q || !pll_enable) begin
            hold_d = 1'b0;
        end
        locked_d = pll_enable && sync2_q && !hold_d;
        // loss only counts after lock was once acquired
        loss_d = acq_q && pll_enable && !sync2_q;
        acq_d = acq_q;
        if (!pll_enable || loss_d) begin
            acq_d = 1'b0;
        end else if (locked_q) begin
            acq_d = 1'b1;
        end
        gate_d = pll_enable && locked_d;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            locked_q <= 1'b0;
            hold_q <= 1'b0;
            acq_q <= 1'b0;
            gate_q <= 1'b0;
        end else begin
            locked_q <= locked_d;
            hold_q <= hold_d;
            acq_q <= acq_d;
            gate_q <= gate_d;
        end
    end

    assign lk.locked = locked_q;
    assign lk.loss_event = loss_d;
    assign pll_clock_gate_en = gate_q;

    sequence seq_relock_attempt;
        locked_q && lk.vdiv_change;
    endsequence

    AST_VDIV_UNLOCK: assert property (@(posedge ref_clk) disable iff (!reset_n)
        seq_relock_attempt |=> !locked_q)
        else $error("locked flag survived a multiplier change");
    AST_GATE_OFF: assert property (@(posedge ref_clk) disable iff (!reset_n)
        !locked_q |-> !gate_q)
        else $error("pll clock gate open without lock");
endmodule
`default_nettype wire

// *** testbench/plm_tb.sv ***
// self-checking bench for the lock status and multiplier block
// assumes the top module alone on ahb-lite, hready looped from hreadyout
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic ref_clk = 1'b0;
    logic reset_n = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0000_0000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0000_0000;
    logic hready;
    logic hreadyout, hresp, pll_clock_gate_en, osc_clock_monitor_enable;
    logic lock_loss_irq, lock_loss_reset_req;
    logic [31:0] hrdata;
    logic [5:0] pll_multiply_factor;
    logic pll_lock_raw = 1'b0;
    logic pll_enable = 1'b0;
    int n_fail = 0;
    int compares = 0;
    logic [31:0] rd;
    logic [31:0] wv;
    assign hready = hreadyout;
    always #25 ref_clk = ~ref_clk;
    plm_top plm_top_i (.ref_clk(ref_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .pll_lock_raw(pll_lock_raw),
        .pll_enable(pll_enable), .pll_clock_gate_en(pll_clock_gate_en),
        .pll_multiply_factor(pll_multiply_factor),
        .osc_clock_monitor_enable(osc_clock_monitor_enable), .lock_loss_irq(lock_loss_irq),
        .lock_loss_reset_req(lock_loss_reset_req));
    task automatic report_and_stop();
        if (n_fail == 0 && compares > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        compares++;
        if (seen !== exp) begin
            n_fail++;
            $display("MISMATCH %0t %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask
    // one single transfer; the wait for hready is bounded by the watchdog
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge ref_clk);
        hsel <= 1'b1;
        haddr <= {24'h00_0000, a};
        htrans <= plm_pkg::HTRANS_NONSEQ;
        hwrite <= wr;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge ref_clk);
        while (hready !== 1'b1) @(posedge ref_clk);
        rd = hrdata;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp, input string what);
        xfer(1'b0, a, 32'h0000_0000);
        check(rd, exp, what);
    endtask
    // lets the two-stage lock synchroniser and the flag register settle
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic set_raw(input logic v);
        @(posedge ref_clk);
        pll_lock_raw <= v;
        tick(6);
    endtask
    initial begin
        tick(20);
        reset_n <= 1'b1;
        tick(1);
        check(pll_multiply_factor, 32'h0000_0018, "factor at reset");
        check(lock_loss_irq | lock_loss_reset_req, 32'h0000_0000, "requests idle");
        check(osc_clock_monitor_enable, 32'h0000_0000, "monitor at reset");
        check(pll_clock_gate_en, 32'h0000_0000, "gate at reset");
        check({hreadyout, hresp}, 32'h0000_0002, "bus ready and okay");
        // bit 6 is written high each time but must read back as zero
        for (int c = 0; c < 32; c++) begin
            wv = (c[0] ? 32'h0000_0020 : 32'h0000_0000) | c;
            wr(plm_pkg::ADDR_VCO_CTRL, wv | 32'h0000_0040);
            tick(2);
            check(pll_multiply_factor, c + 24, "multiply factor");
            check(osc_clock_monitor_enable, c[0], "monitor enable");
            rd_chk(plm_pkg::ADDR_VCO_CTRL, wv, "ctrl readback");
        end
        wr(plm_pkg::ADDR_VCO_CTRL, 32'h0000_0083);
        wr(plm_pkg::ADDR_LOCK_CFG, 32'h0000_0001);
        @(posedge ref_clk);
        pll_enable <= 1'b1;
        tick(6);
        check(pll_clock_gate_en, 32'h0000_0000, "gate while unlocked");
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0000, "no loss before lock");
        set_raw(1'b1);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0040, "locked status");
        check(pll_clock_gate_en, 32'h0000_0001, "gate once locked");
        check(lock_loss_irq, 32'h0000_0000, "no irq while locked");
        set_raw(1'b0);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0080, "loss flag set");
        check(lock_loss_irq, 32'h0000_0001, "irq on loss");
        check(lock_loss_reset_req, 32'h0000_0001, "reset request on loss");
        check(pll_clock_gate_en, 32'h0000_0000, "gate after loss");
        set_raw(1'b1);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_00c0, "loss sticky over relock");
        wr(plm_pkg::ADDR_STATUS, 32'h0000_0000);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_00c0, "write zero ignored");
        wr(plm_pkg::ADDR_STATUS, 32'h0000_0080);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0040, "write one clears");
        tick(1);
        check(lock_loss_irq, 32'h0000_0000, "irq drops with flag");
        // both enables off: a loss must set the flag and raise nothing
        wr(plm_pkg::ADDR_VCO_CTRL, 32'h0000_0003);
        wr(plm_pkg::ADDR_LOCK_CFG, 32'h0000_0000);
        set_raw(1'b0);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0080, "loss without enables");
        check(lock_loss_irq, 32'h0000_0000, "irq masked");
        check(lock_loss_reset_req, 32'h0000_0000, "reset request masked");
        wr(plm_pkg::ADDR_STATUS, 32'h0000_0080);
        set_raw(1'b1);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0040, "relocked");
        wr(plm_pkg::ADDR_VCO_CTRL, 32'h0000_0004);
        tick(6);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0000, "select change unlocks");
        check(pll_clock_gate_en, 32'h0000_0000, "gate after select change");
        set_raw(1'b0);
        set_raw(1'b1);
        xfer(1'b0, plm_pkg::ADDR_STATUS, 32'h0000_0000);
        check(rd[6], 32'h0000_0001, "relock after detector cycle");
        // a dropped enable is not a loss of lock
        wr(plm_pkg::ADDR_STATUS, 32'h0000_0080);
        @(posedge ref_clk);
        pll_enable <= 1'b0;
        tick(6);
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0000, "no loss while disabled");
        check(pll_clock_gate_en, 32'h0000_0000, "gate while disabled");
        @(posedge ref_clk);
        pll_enable <= 1'b1;
        tick(6);
        check(pll_clock_gate_en, 32'h0000_0001, "gate after enable");
        rd_chk(8'h40, 32'h0000_0000, "unmapped read");
        wr(8'h40, 32'h0000_001f);
        rd_chk(plm_pkg::ADDR_VCO_CTRL, 32'h0000_0004, "unmapped write ignored");
        wr(plm_pkg::ADDR_VCO_CTRL, 32'h0000_0084);
        wr(plm_pkg::ADDR_LOCK_CFG, 32'h0000_0001);
        set_raw(1'b0);
        check(lock_loss_reset_req, 32'h0000_0001, "reset request before reset");
        @(posedge ref_clk);
        reset_n <= 1'b0;
        tick(3);
        reset_n <= 1'b1;
        rd_chk(plm_pkg::ADDR_STATUS, 32'h0000_0000, "reset clears flag");
        check(pll_multiply_factor, 32'h0000_0018, "factor after reset");
        check(lock_loss_irq | lock_loss_reset_req, 32'h0000_0000, "requests cleared");
        report_and_stop();
    end
    // the tests take well under 2000 cycles
    initial begin
        tick(20000);
        n_fail++;
        report_and_stop();
    end
endmodule
`default_nettype wire
